// ==== pkg/dofs_regs.vh ====
`ifndef DOFS_REGS_VH
`define DOFS_REGS_VH

// Register byte offsets
`define DOFS_RELAY1_SEL_OFF  8'h00
`define DOFS_OC_SEL_OFF      8'h04
`define DOFS_EXT3_SEL_OFF    8'h08
`define DOFS_EXT4_SEL_OFF    8'h0c
`define DOFS_DET_FREQ_OFF    8'h10
`define DOFS_DET_BAND_OFF    8'h14
`define DOFS_MAX_FREQ_OFF    8'h18
`define DOFS_OUT_STAT_OFF    8'h1c

// Field widths
`define DOFS_SEL_W           6
`define DOFS_FREQ_W          16

// Function codes
`define DOFS_FN_NONE         6'h00
`define DOFS_FN_REACHED      6'h01
`define DOFS_FN_AT_POINT     6'h02
`define DOFS_FN_IN_BAND      6'h03
`define DOFS_FN_RUN          6'h0e
`define DOFS_FN_TRIP         6'h1d

// Reset values, frequencies in 0.01 Hz steps
`define DOFS_RELAY1_SEL_RST  6'h1d
`define DOFS_OC_SEL_RST      6'h0e
`define DOFS_EXT_SEL_RST     6'h00
`define DOFS_DET_FREQ_RST    16'h0bb8
`define DOFS_DET_BAND_RST    16'h03e8
`define DOFS_MAX_FREQ_RST    16'h1770

`endif

// ==== hw/dofs_top.v ====
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
`include "dofs_regs.vh"

module dofs_top #(
  parameter FREQ_W = `DOFS_FREQ_W,
  parameter SEL_W  = `DOFS_SEL_W
) (
  // APB slave
  input  wire              pclk,
  input  wire              presetn,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [7:0]        paddr,
  input  wire [31:0]       pwdata,
  output wire              pready,
  output wire              pslverr,
  output wire [31:0]       prdata,
  // Drive state from control logic, same clock
  input  wire [FREQ_W-1:0] set_freq,
  input  wire [FREQ_W-1:0] output_freq,
  input  wire              trip_active,
  input  wire              run_active,
  // Digital outputs
  output wire              relay_one_out,
  output wire              open_collector_output,
  output wire              ext_relay_three_out,
  output wire              ext_relay_four_out
);

  // Settings held for the output decode
  reg  [SEL_W-1:0]  relay_one_select_q;
  reg  [SEL_W-1:0]  open_collector_select_q;
  reg  [SEL_W-1:0]  ext_relay_three_select_q;
  reg  [SEL_W-1:0]  ext_relay_four_select_q;
  reg  [FREQ_W-1:0] detect_frequency_setting_q;
  reg  [FREQ_W-1:0] detect_band_setting_q;
  reg  [FREQ_W-1:0] max_freq_q;
  reg  [3:0]        outs_q;
  reg  [3:0]        outs_d;
  reg  [31:0]       rdata_d;
  reg               unmapped_d;
  // Bus decode strobes and comparison results
  wire              wr_en;
  wire [FREQ_W-1:0] wr_freq;
  wire              freq_reached_compare;
  wire              freq_reached_at_detect_point;
  wire              output_freq_in_detect_band;

  // True when twice the distance stays under the band, i.e. under band/2
  function within_half_band;
    input [FREQ_W-1:0] a;
    input [FREQ_W-1:0] b;
    input [FREQ_W-1:0] band;
    reg   [FREQ_W-1:0] diff;
    begin
      diff = (a > b) ? (a - b) : (b - a);
      // Doubling the difference keeps the odd bit that band/2 would lose
      within_half_band = ({diff, 1'b0} < {1'b0, band});
    end
  endfunction

  // Trip and run come from the drive core; other codes are not built
  // Shared decode so all four outputs see one table
  function select_fn;
    input [SEL_W-1:0] code;
    input             c1;
    input             c2;
    input             c3;
    input             trip;
    input             run;
    begin
      case (code)
        `DOFS_FN_NONE:     select_fn = 1'b0;
        `DOFS_FN_REACHED:  select_fn = c1;
        `DOFS_FN_AT_POINT: select_fn = c2;
        `DOFS_FN_IN_BAND:  select_fn = c3;
        `DOFS_FN_RUN:      select_fn = run;
        `DOFS_FN_TRIP:     select_fn = trip;
        default:           select_fn = 1'b0; // Codes not built here stay off
      endcase
    end
  endfunction

  // Zero-wait slave; writes land at the access edge
  assign pready  = 1'b1;
  assign wr_en   = psel & penable & pwrite & ~unmapped_d;
  assign pslverr = psel & penable & unmapped_d;
  assign prdata  = (psel & penable & ~pwrite) ? rdata_d : 32'h00000000;

  // Detect frequency never stored above the maximum frequency
  assign wr_freq = (pwdata[FREQ_W-1:0] > max_freq_q) ? max_freq_q : pwdata[FREQ_W-1:0];

  // Read mux and address decode
  always @* begin
    rdata_d    = 32'h00000000;
    unmapped_d = 1'b0;
    case (paddr)
      `DOFS_RELAY1_SEL_OFF: rdata_d[SEL_W-1:0]  = relay_one_select_q;
      `DOFS_OC_SEL_OFF:     rdata_d[SEL_W-1:0]  = open_collector_select_q;
      `DOFS_EXT3_SEL_OFF:   rdata_d[SEL_W-1:0]  = ext_relay_three_select_q;
      `DOFS_EXT4_SEL_OFF:   rdata_d[SEL_W-1:0]  = ext_relay_four_select_q;
      `DOFS_DET_FREQ_OFF:   rdata_d[FREQ_W-1:0] = detect_frequency_setting_q;
      `DOFS_DET_BAND_OFF:   rdata_d[FREQ_W-1:0] = detect_band_setting_q;
      `DOFS_MAX_FREQ_OFF:   rdata_d[FREQ_W-1:0] = max_freq_q;
      `DOFS_OUT_STAT_OFF:   rdata_d[3:0]        = outs_q;
      default:              unmapped_d          = 1'b1;
    endcase
  end

  // Configuration registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      relay_one_select_q         <= `DOFS_RELAY1_SEL_RST;
      open_collector_select_q    <= `DOFS_OC_SEL_RST;
      ext_relay_three_select_q   <= `DOFS_EXT_SEL_RST;
      ext_relay_four_select_q    <= `DOFS_EXT_SEL_RST;
      detect_frequency_setting_q <= `DOFS_DET_FREQ_RST;
      detect_band_setting_q      <= `DOFS_DET_BAND_RST;
      max_freq_q                 <= `DOFS_MAX_FREQ_RST;
    end else if (wr_en) begin
      case (paddr)
        `DOFS_RELAY1_SEL_OFF: relay_one_select_q       <= pwdata[SEL_W-1:0];
        `DOFS_OC_SEL_OFF:     open_collector_select_q  <= pwdata[SEL_W-1:0];
        `DOFS_EXT3_SEL_OFF:   ext_relay_three_select_q <= pwdata[SEL_W-1:0];
        `DOFS_EXT4_SEL_OFF:   ext_relay_four_select_q  <= pwdata[SEL_W-1:0];
        `DOFS_DET_FREQ_OFF:   detect_frequency_setting_q <= wr_freq;
        `DOFS_DET_BAND_OFF:   detect_band_setting_q    <= pwdata[FREQ_W-1:0];
        `DOFS_MAX_FREQ_OFF: begin
          max_freq_q <= pwdata[FREQ_W-1:0];
          // Lowering the maximum pulls the detect point with it
          if (detect_frequency_setting_q > pwdata[FREQ_W-1:0]) begin
            detect_frequency_setting_q <= pwdata[FREQ_W-1:0];
          end
        end
        default: ;
      endcase
    end
  end

  // Frequency comparisons
  assign freq_reached_compare = within_half_band(set_freq, output_freq,
                                                 detect_band_setting_q);
  assign freq_reached_at_detect_point = freq_reached_compare &
    within_half_band(set_freq, detect_frequency_setting_q, detect_band_setting_q);
  assign output_freq_in_detect_band = within_half_band(output_freq,
    detect_frequency_setting_q, detect_band_setting_q);

  // Per-output selection through one table
  always @* begin
    outs_d[0] = select_fn(relay_one_select_q, freq_reached_compare,
      freq_reached_at_detect_point, output_freq_in_detect_band, trip_active, run_active);
    outs_d[1] = select_fn(open_collector_select_q, freq_reached_compare,
      freq_reached_at_detect_point, output_freq_in_detect_band, trip_active, run_active);
    outs_d[2] = select_fn(ext_relay_three_select_q, freq_reached_compare,
      freq_reached_at_detect_point, output_freq_in_detect_band, trip_active, run_active);
    outs_d[3] = select_fn(ext_relay_four_select_q, freq_reached_compare,
      freq_reached_at_detect_point, output_freq_in_detect_band, trip_active, run_active);
  end

  // Plain register, follows the comparison every cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      outs_q <= 4'h0;
    end else begin
      outs_q <= outs_d;
    end
  end

  // Output pins straight from the registered levels
  assign relay_one_out         = outs_q[0];
  assign open_collector_output = outs_q[1];
  assign ext_relay_three_out   = outs_q[2];
  assign ext_relay_four_out    = outs_q[3];
  // Status read shows these same four levels

endmodule // dofs_top

// ==== verif/dofs_load_model.sv ====
`timescale 1ns/1ns
// Relay coils and open-collector line; that line idles high on its pull-up
module dofs_load_model (
  // Outputs of the block, then levels at the loads
  input  wire logic [3:0] drive,
  output wire logic [3:0] line
);
  // Transistor on pulls the line low
  assign line = {drive[3:2], ~drive[1], drive[0]};
endmodule // dofs_load_model

// ==== verif/dofs_checker.sv ====
`timescale 1ns/1ns
`include "dofs_regs.vh"
module dofs_checker (
  // Bus
  input wire logic        pclk, presetn, psel, penable, pwrite, pready, pslverr,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata, prdata,
  // Drive state and outputs
  input wire logic [15:0] set_freq, output_freq,
  input wire logic        trip_active, run_active, relay_one_out, open_collector_output,
  input wire logic        ext_relay_three_out, ext_relay_four_out
);
  logic [5:0]  sel_q [4];
  logic [15:0] det_q, band_q;
  logic [3:0]  exp_w;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Shadow settings; clamp limits the detect frequency to the fixed reset maximum 16'h1770, not to the writable maximum frequency
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_q  <= '{`DOFS_RELAY1_SEL_RST, `DOFS_OC_SEL_RST, 6'h00, 6'h00};
      det_q  <= `DOFS_DET_FREQ_RST;
      band_q <= `DOFS_DET_BAND_RST;
    end else if (psel && penable && pwrite) begin
      if (paddr < 8'h10) sel_q[paddr[3:2]] <= pwdata[5:0];
      if (paddr == 8'h10) det_q <= (pwdata[15:0] > 16'h1770) ? 16'h1770 : pwdata[15:0];
      if (paddr == 8'h14) band_q <= pwdata[15:0];
    end
  end
  function automatic logic near(input logic [15:0] a, b);
    near = (((a > b) ? {1'b0, a - b} : {1'b0, b - a}) << 1) < {1'b0, band_q};
  endfunction
  function automatic logic hit(input logic [5:0] c);
    case (c)
      6'h01: hit = near(set_freq, output_freq);
      6'h02: hit = near(set_freq, output_freq) && near(set_freq, det_q);
      6'h03: hit = near(output_freq, det_q);
      6'h0e: hit = run_active;
      6'h1d: hit = trip_active;
      default: hit = 1'b0;
    endcase
  endfunction
  // Expected level of each output after the next edge
  // Signals read only inside the functions must wake this process too
  always_comb for (int i = 0; i < 4; i++) exp_w[i] = hit(sel_q[i]);
  relay_one_fn_a: assert property ($past(presetn) |-> relay_one_out == $past(exp_w[0]))
    else $error("relay one wrong");
  oc_fn_a: assert property ($past(presetn) |-> open_collector_output == $past(exp_w[1]))
    else $error("open collector wrong");
  ext_three_a: assert property ($past(presetn) |-> ext_relay_three_out == $past(exp_w[2]))
    else $error("relay three wrong");
  ext_four_a: assert property ($past(presetn) |-> ext_relay_four_out == $past(exp_w[3]))
    else $error("relay four wrong");
  code_zero_off_a: assert property (sel_q[3] == 6'h00 |=> !ext_relay_four_out)
    else $error("code zero output active");
  band_read_a: assert property (psel && penable && !pwrite && paddr == 8'h14
    |-> prdata[15:0] == band_q) else $error("band readback wrong");
  unmapped_err_a: assert property (psel && penable |-> pslverr == (paddr > 8'h1c))
    else $error("error response wrong");
  idle_rdata_a: assert property (!(psel && penable) |-> prdata == 32'h0)
    else $error("read data outside access");
  cover property (ext_relay_three_out);
  cover property (relay_one_out && sel_q[0] == 6'h03);
  cover property (psel && penable && pslverr);
endmodule // dofs_checker

bind dofs_top dofs_checker u_dofs_checker (.pclk, .presetn, .psel, .penable, .pwrite,
  .pready, .pslverr, .paddr, .pwdata, .prdata, .set_freq, .output_freq, .trip_active,
  .run_active, .relay_one_out, .open_collector_output, .ext_relay_three_out,
  .ext_relay_four_out);

// ==== verif/dofs_tb_top.sv ====
`timescale 1ns/1ns
module dofs_tb_top;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic        trip_active = 0, run_active = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd_v;
  logic [15:0] set_freq = 16'h0, output_freq = 16'h0;
  logic [3:0]  outs, line;
  logic        rd_e;
  int          error_cnt = 0, num_checks = 0;
  logic [7:0]  ra [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
  logic [31:0] rv [6] = '{32'h1d, 32'h0e, 32'h0, 32'h0, 32'h0bb8, 32'h03e8};
  logic [15:0] sv [5] = '{16'h0bb8, 16'h0bb8, 16'h0e10, 16'h09c5, 16'h1388};
  logic [15:0] ov [5] = '{16'h0a28, 16'h09c4, 16'h0c80, 16'h09c5, 16'h09c5};
  logic [3:0]  ev [5] = '{4'h7, 4'h0, 4'h3, 4'h7, 4'h1};
  initial forever #25 pclk = ~pclk;
  dofs_top u_dofs_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .pslverr, .prdata, .set_freq, .output_freq, .trip_active, .run_active,
    .relay_one_out(outs[0]), .open_collector_output(outs[1]),
    .ext_relay_three_out(outs[2]), .ext_relay_four_out(outs[3]));
  dofs_load_model u_dofs_load_model (.drive(outs), .line(line));
  task results;
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One bus transfer, entered and left just after an edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_v = prdata;
    rd_e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Outputs register one edge late; the extra edge lets them settle
  task chk_out(input logic [3:0] e);
    repeat (2) @(posedge pclk);
    #1 chk({28'h0, outs}, {28'h0, e});
    chk({28'h0, line}, {28'h0, e ^ 4'h2});
    @(posedge pclk);
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 6; i++) begin apb(1'b0, ra[i], 32'h0); chk(rd_v, rv[i]); end
    apb(1'b0, 8'h20, 32'h0); chk(rd_v, 32'h0);
    chk({31'h0, rd_e}, 32'h1);
    trip_active <= 1'b1; chk_out(4'h1);
    trip_active <= 1'b0; run_active <= 1'b1; chk_out(4'h2);
    apb(1'b1, 8'h10, 32'h1b58); apb(1'b0, 8'h10, 32'h0); chk(rd_v, 32'h1770);
    apb(1'b1, 8'h10, 32'h0bb8); apb(1'b1, 8'h00, 32'h3);
    apb(1'b1, 8'h04, 32'h1); apb(1'b1, 8'h08, 32'h2);
    // Boundary rows: a difference of exactly half the band must not count
    for (int i = 0; i < 5; i++) begin
      set_freq <= sv[i]; output_freq <= ov[i]; chk_out(ev[i]);
    end
    apb(1'b0, 8'h1c, 32'h0); chk(rd_v, {28'h0, ev[4]});
    results;
  end
  // Run needs about 85 cycles; 2000 cycles, over twenty times that, means a hang
  initial begin
    #100000;
    error_cnt++;
    results;
  end
endmodule // dofs_tb_top
